/* File: logic/uii_defines.vh */
// Constants for the interrupt identification block.
// Assumes inclusion by bare name from files under logic/.
`ifndef UII_DEFINES_VH
`define UII_DEFINES_VH

// Register addresses (port 0 and port 1)
`define UII_ADDR_PORT0     8'hC2
`define UII_ADDR_PORT1     8'hD2
`define UII_ADDR_W         8

// Field positions
`define UII_FIFO_IND_HI    7
`define UII_FIFO_IND_LO    6
`define UII_CODE_HI        3
`define UII_CODE_LO        1
`define UII_NOPEND_BIT     0

// Reset value
`define UII_RESET_VAL      8'h01

// Field values
`define UII_FIFO_ON_IND    2'h3
`define UII_FIFO_OFF_IND   2'h0

// Status codes
`define UII_CODE_LINE      3'h3
`define UII_CODE_RXDATA    3'h2
`define UII_CODE_TIMEOUT   3'h6
`define UII_CODE_TXEMPTY   3'h1
`define UII_CODE_MODEM     3'h0

// Receive threshold select
`define UII_THR_1          2'h0
`define UII_THR_4          2'h1
`define UII_THR_8          2'h2
`define UII_THR_14         2'h3
`define UII_THR_1_BYTES    5'h01
`define UII_THR_4_BYTES    5'h04
`define UII_THR_8_BYTES    5'h08
`define UII_THR_14_BYTES   5'h0E

`endif

/* File: logic/uii_prio_enc.v */
// Priority encoder from gated interrupt sources to a status code.
// Assumes all source inputs already qualified by their enables.
`default_nettype none
`include "uii_defines.vh"

module uii_prio_enc (
  input  wire       src_line,
  input  wire       src_rxdata,
  input  wire       src_timeout,
  input  wire       src_txempty,
  input  wire       src_modem,
  output reg  [2:0] code,
  output reg        any_pending
);

  // ******************************
  // Priority selection
  // ******************************
  always @* begin
    any_pending = src_line | src_rxdata | src_timeout | src_txempty |
                  src_modem;
    // Lower codes only surface once every higher source has cleared
    if (src_line) begin
      code = `UII_CODE_LINE;             // RL6
    end else if (src_rxdata) begin
      code = `UII_CODE_RXDATA;           // RL6
    end else if (src_timeout) begin
      code = `UII_CODE_TIMEOUT;          // RL6
    end else if (src_txempty) begin
      code = `UII_CODE_TXEMPTY;          // RL7
    end else begin
      code = `UII_CODE_MODEM;            // RL7
    end
  end

endmodule
`default_nettype wire

/* File: logic/uii_top.v */
// Interrupt identification register for one serial port.
// Assumes sources and register strobes are synchronous to core_clk.
//
// What this block does
// RL1 - Read-only register sharing FIFO control address
// RL2 - Bits 7:6 show 11 when FIFOs on
// RL3 - Status code in bits 3:1 with bit 0
// RL4 - Only highest-priority enabled source is reported
// RL5 - Lower codes appear once higher ones clear
// RL6 - Line 011, data 010, time-out 110
// RL7 - Transmit empty 001, modem change 000
// RL8 - Bit 0 low when pending; reset 0x01
// RL9 - Line source on parity, framing, overrun, break
// RL10 - One receive enable governs data and time-out
// RL11 - Transmit source when transmit FIFO empty
// RL12 - With FIFOs, data ready at fill threshold
`default_nettype none
`include "uii_defines.vh"

module uii_top #(
  parameter [7:0] REG_ADDR = `UII_ADDR_PORT0,
  parameter       FILL_W   = 5
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              reset,
  // Register bus
  input  wire [7:0]        reg_addr,
  input  wire              reg_rd,
  input  wire              reg_wr,
  // FIFO state and receive fill
  input  wire              fifo_on,
  input  wire [1:0]        rx_fill_threshold,
  input  wire [FILL_W-1:0] rx_fill_count,
  // Event sources
  input  wire              rx_byte_ready,
  input  wire              rx_timeout,
  input  wire              parity_err,
  input  wire              framing_err,
  input  wire              overrun_err,
  input  wire              break_det,
  input  wire              tx_fifo_empty,
  input  wire              modem_change,
  // Interrupt enables
  input  wire              line_status_irq_enable,
  input  wire              rx_irq_enable,
  input  wire              tx_empty_irq_enable,
  input  wire              modem_change_irq_enable,
  // Register port answers and live state
  output reg  [7:0]        rd_data_ff,
  output reg               rd_valid_ff,
  output reg               fifo_ctl_wr_ff,
  output reg  [7:0]        interrupt_identification_reg_ff,
  output reg               irq_pending_ff
);

  // ******************************
  // Declarations
  // ******************************
  reg  [FILL_W-1:0] thr_bytes;
  wire              rx_level_hit;
  reg               src_line;
  reg               src_rxdata;
  reg               src_timeout;
  reg               src_txempty;
  reg               src_modem;
  wire [2:0]        code;
  wire              any_pending;
  wire              line_cause;
  wire              addr_hit;
  wire              rd_take;
  wire              wr_take;
  wire [1:0]        fifo_field;
  wire [2:0]        code_field;
  wire              no_pending;
  reg  [7:0]        nxt_ident;
  reg  [7:0]        nxt_rd_data;

  // ******************************
  // Receive fill threshold
  // ******************************
  // The select only matters with FIFOs on; without them the
  // holding buffer flag is used instead
  always @* begin
    thr_bytes = `UII_THR_1_BYTES;
    case (rx_fill_threshold)
      `UII_THR_1: begin
        thr_bytes = `UII_THR_1_BYTES;
      end
      `UII_THR_4: begin
        thr_bytes = `UII_THR_4_BYTES;
      end
      `UII_THR_8: begin
        thr_bytes = `UII_THR_8_BYTES;
      end
      `UII_THR_14: begin
        thr_bytes = `UII_THR_14_BYTES;
      end
      default: begin
        thr_bytes = `UII_THR_1_BYTES;
      end
    endcase
  end

  // ******************************
  // Source qualification
  // ******************************
  // Without FIFOs the one-byte holding buffer decides readiness
  assign rx_level_hit = fifo_on ? (rx_fill_count >= thr_bytes) // RL12
                                : rx_byte_ready;
  // Any one receive error raises the line status source
  assign line_cause = parity_err | framing_err | overrun_err |
                      break_det;                                 // RL9

  // An enable masks its source before priority, so a disabled
  // high-priority source never hides an enabled lower one
  always @* begin
    src_line    = 1'b0;
    src_rxdata  = 1'b0;
    src_timeout = 1'b0;
    src_txempty = 1'b0;
    src_modem   = 1'b0;
    if (line_status_irq_enable) begin
      src_line = line_cause;                                     // RL9
    end
    if (rx_irq_enable) begin
      src_rxdata  = rx_level_hit;                                // RL10
      src_timeout = rx_timeout;                                  // RL10
    end
    if (tx_empty_irq_enable) begin
      src_txempty = tx_fifo_empty;                               // RL11
    end
    if (modem_change_irq_enable) begin
      src_modem = modem_change;
    end
  end

  uii_prio_enc u_prio (
    .src_line    (src_line),
    .src_rxdata  (src_rxdata),
    .src_timeout (src_timeout),
    .src_txempty (src_txempty),
    .src_modem   (src_modem),
    .code        (code),
    .any_pending (any_pending)
  );                                                             // RL4 RL5

  // ******************************
  // Identification register
  // ******************************
  assign fifo_field = fifo_on ? `UII_FIFO_ON_IND
                              : `UII_FIFO_OFF_IND;               // RL2
  // Code forced to zero when idle so bit 0 alone tells the story
  assign code_field = any_pending ? code : 3'h0;                 // RL3
  assign no_pending = ~any_pending;                              // RL8

  always @* begin
    nxt_ident = 8'h00;                                           // RL8
    nxt_ident[`UII_FIFO_IND_HI:`UII_FIFO_IND_LO] = fifo_field;   // RL2
    nxt_ident[`UII_CODE_HI:`UII_CODE_LO]         = code_field;   // RL3
    nxt_ident[`UII_NOPEND_BIT]                   = no_pending;   // RL8
  end

  // Live value lags the sources by one edge
  always @(posedge core_clk) begin
    if (reset) begin
      interrupt_identification_reg_ff <= `UII_RESET_VAL;         // RL8
    end else begin
      interrupt_identification_reg_ff <= nxt_ident;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      irq_pending_ff <= 1'b0;
    end else begin
      irq_pending_ff <= any_pending;
    end
  end

  // ******************************
  // Register port decode
  // ******************************
  assign addr_hit = (reg_addr == REG_ADDR);
  assign rd_take  = reg_rd & addr_hit;                           // RL1
  // Writes at this address belong to FIFO control, never here
  assign wr_take  = reg_wr & addr_hit;                           // RL1

  // Read data is the register as it stood at the read edge, and
  // zero otherwise so that several ports can share one read bus
  always @* begin
    nxt_rd_data = 8'h00;
    if (rd_take) begin
      nxt_rd_data = interrupt_identification_reg_ff;             // RL1
    end
  end

  // ******************************
  // Register port outputs
  // ******************************
  always @(posedge core_clk) begin
    if (reset) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_take;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      fifo_ctl_wr_ff <= 1'b0;
    end else begin
      fifo_ctl_wr_ff <= wr_take;                                 // RL1
    end
  end

endmodule
`default_nettype wire

/* File: testbench/uii_top_props.sv */
// Checker on the read, write and pending outputs of uii_top.
// Assumes a bind from the bench that hands on REG_ADDR.
`default_nettype none
module uii_top_props #(
  parameter [7:0] REG_ADDR = 8'hC2
) (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic       fifo_on,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] rd_data_ff,
  input wire logic       rd_valid_ff,
  input wire logic       fifo_ctl_wr_ff,
  input wire logic [7:0] interrupt_identification_reg_ff,
  input wire logic       irq_pending_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic hit = reg_addr == REG_ADDR;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_rd_pulse: assert property (!$past(reset) |->
    rd_valid_ff == $past(reg_rd && hit)) else $error("read pulse");
  chk_wr_fwd: assert property (!$past(reset) |->
    fifo_ctl_wr_ff == $past(reg_wr && hit)) else $error("write pulse");
  chk_rd_idle: assert property (!rd_valid_ff |-> rd_data_ff == 8'h00)
    else $error("idle data");
  // Sources reach the read data two edges after they are sampled
  chk_fifo_field: assert property (rd_valid_ff && !$past(reset, 2) |->
    rd_data_ff[7:6] == {2{$past(fifo_on, 2)}}) else $error("fifo field");
  chk_rsvd_zero: assert property (rd_valid_ff |->
    rd_data_ff[5:4] == 2'h0) else $error("reserved bits");
  chk_pend_bit: assert property (rd_valid_ff |->
    rd_data_ff[0] != $past(irq_pending_ff)) else $error("pending bit");
  chk_idle_code: assert property (rd_valid_ff && rd_data_ff[0] |->
    rd_data_ff[3:1] == 3'h0) else $error("idle code");
  chk_code_legal: assert property (rd_valid_ff |->
    rd_data_ff[3:1] inside {3'h3, 3'h2, 3'h6, 3'h1, 3'h0})
    else $error("status code");
  chk_live_copy: assert property (rd_valid_ff |->
    rd_data_ff == $past(interrupt_identification_reg_ff))
    else $error("read copy");
  chk_live_pend: assert property (
    interrupt_identification_reg_ff[0] != irq_pending_ff)
    else $error("live pending bit");
endmodule
`default_nettype wire

/* File: testbench/uii_top_tb.sv */
// Bench for uii_top at the port 0 address with random sources and strobes.
// Assumes the design files and uii_top_props are compiled first.
`default_nettype none
bind uii_top uii_top_props #(.REG_ADDR(REG_ADDR)) chk_u (.core_clk, .reset,
  .reg_rd, .reg_wr, .fifo_on, .reg_addr, .rd_data_ff, .rd_valid_ff,
  .fifo_ctl_wr_ff, .interrupt_identification_reg_ff, .irq_pending_ff);
module uii_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'h0;
  logic        reset, reg_rd, reg_wr;
  logic [7:0]  reg_addr, q[$];
  logic [19:0] s, v;
  logic [31:0] x;
  logic [7:0]  ad [4] = '{8'hC2, 8'hD2, 8'hC2, 8'h00};
  logic [4:0]  thr [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  wire  [7:0]  rd_data_ff;
  wire         rd_valid_ff;
  int          errors = 0, num_checks = 0, cyc = 0;
  uii_top #(.REG_ADDR(8'hC2)) dut_u (.core_clk, .reset, .reg_rd, .reg_wr,
    .reg_addr, .fifo_on(s[14]), .rx_fill_threshold(s[13:12]),
    .rx_fill_count(s[19:15]), .rx_byte_ready(s[11]), .rx_timeout(s[10]),
    .parity_err(s[9]), .framing_err(s[8]), .overrun_err(s[7]),
    .break_det(s[6]), .tx_fifo_empty(s[5]), .modem_change(s[4]),
    .line_status_irq_enable(s[3]), .rx_irq_enable(s[2]),
    .tx_empty_irq_enable(s[1]), .modem_change_irq_enable(s[0]),
    .rd_data_ff, .rd_valid_ff, .fifo_ctl_wr_ff(),
    .interrupt_identification_reg_ff(), .irq_pending_ff());
  initial forever #10 core_clk = ~core_clk;
  function automatic logic [31:0] xs(logic [31:0] r);
    r = r ^ (r << 13);
    r = r ^ (r >> 17);
    xs = r ^ (r << 5);
  endfunction
  // Later lines win, so the order below is lowest priority first
  function automatic logic [7:0] exp_ident(logic [19:0] e);
    exp_ident = {{2{e[14]}}, 6'h01};
    if (e[0] && e[4]) exp_ident[3:0] = 4'h0;
    if (e[1] && e[5]) exp_ident[3:0] = 4'h2;
    if (e[2] && e[10]) exp_ident[3:0] = 4'hC;
    if (e[2] && (e[14] ? e[19:15] >= thr[e[13:12]] : e[11]))
      exp_ident[3:0] = 4'h4;
    if (e[3] && |e[9:6]) exp_ident[3:0] = 4'h6;
  endfunction
  task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) errors++;
    if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
  endtask
  task automatic final_report;
    // A read left unanswered counts as a mismatch
    if (q.size() != 0) errors++;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) errors++;
    if (cyc == 2000) final_report;
    if (rd_valid_ff === 1'h1 && q.size() == 0)
      cmp8("stray_read", 8'h00, 8'hFF);
    else if (rd_valid_ff === 1'h1)
      cmp8("ident", q.pop_front(), rd_data_ff);
  end
  initial begin
    {reset, reg_rd, reg_wr, reg_addr, s, v, x} = {3'h4, 48'h0, 32'hE050};
    repeat (20) @(posedge core_clk);
    reset <= 1'h0;
    // First pass keeps all sources quiet to see the reset value
    repeat (300) begin
      @(posedge core_clk);
      s <= v;
      reg_wr <= x[31];
      reg_addr <= ad[x[30:29]];
      @(posedge core_clk);
      reg_wr <= 1'h0;
      reg_rd <= 1'h1;
      reg_addr <= ad[x[28:27]];
      if (ad[x[28:27]] == 8'hC2) q.push_back(exp_ident(v));
      @(posedge core_clk);
      reg_rd <= 1'h0;
      x = xs(x);
      v = {x[20:16] % 5'h11, x[14:0]};
    end
    repeat (4) @(posedge core_clk);
    final_report;
  end
endmodule
`default_nettype wire
